// ===== shared/lite_timer_pkg.sv
// Shared constants, register map and field layout of the dual timebase capture timer
package lite_timer_pkg;

  // ----------------------------------------------------------------
  // Clock division
  // ----------------------------------------------------------------
  localparam int unsigned PRESCALE = 32;
  localparam int unsigned PRESCALE_W = 5;
  localparam logic [PRESCALE_W-1:0] PRESCALE_LAST = 5'(PRESCALE - 1);

  // ----------------------------------------------------------------
  // Counter limits and timebase periods in oscillator clocks
  // ----------------------------------------------------------------
  localparam logic [7:0] C1_LAST = 8'hF9;
  localparam logic [7:0] C2_LAST = 8'hFF;
  localparam logic [7:0] ZERO8 = 8'h00;
  localparam int unsigned TB_SHORT_OSC = 8000;
  localparam int unsigned TB_LONG_OSC = 16000;

  // ----------------------------------------------------------------
  // Register indices; byte address is four times the index
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 12;
  localparam logic [7:0] IDX_CSR2 = 8'h08;
  localparam logic [7:0] IDX_RELOAD = 8'h09;
  localparam logic [7:0] IDX_COUNT2 = 8'h0A;
  localparam logic [7:0] IDX_CSR1 = 8'h0B;
  localparam logic [7:0] IDX_CAPTURE = 8'h0C;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned B_CAP_IE = 7;
  localparam int unsigned B_CAP_FLAG = 6;
  localparam int unsigned B_PERIOD = 5;
  localparam int unsigned B_TB1_IE = 4;
  localparam int unsigned B_TB1_FLAG = 3;
  localparam int unsigned B_TB2_IE = 1;
  localparam int unsigned B_TB2_FLAG = 0;

  // Software controlled bits, all reset to zero
  typedef struct packed {
    logic capture_irq_enable;
    logic period_select;
    logic timebase_one_irq_enable;
    logic timebase_two_irq_enable;
  } ctrl_t;

  localparam ctrl_t CTRL_RESET = '0;

  // Decode a byte address to a register index; non word aligned gives 8'hFF
  function automatic logic [7:0] reg_index(input logic [ADDR_W-1:0] addr);
    if (addr[1:0] != 2'h0) begin
      return 8'hFF;
    end
    return {2'h0, addr[7:2]};
  endfunction

endpackage

// ===== design/tick_divider.sv
// Divider that turns the oscillator clock into a one-cycle counting enable
`timescale 1ns/1ns
`default_nettype none
module tick_divider (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  output logic tick
);

  logic [lite_timer_pkg::PRESCALE_W-1:0] count;

  // Frozen while stopped, so counting resumes with the same phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= '0;
    end else if (run) begin
      count <= count + 1'b1;
    end
  end

  assign tick = run && (count == lite_timer_pkg::PRESCALE_LAST);

endmodule // tick_divider
`default_nettype wire

// ===== design/edge_sync.sv
// Two-stage synchroniser with both-edge detector for the capture pin
`timescale 1ns/1ns
`default_nettype none
module edge_sync (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pin,
  output logic any_edge
);

  logic meta;
  logic stable;
  logic last;

  // First stage is read only by the second stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta <= 1'b0;
      stable <= 1'b0;
      last <= 1'b0;
    end else begin
      meta <= pin;
      stable <= meta;
      last <= stable;
    end
  end

  assign any_edge = stable ^ last;

endmodule // edge_sync
`default_nettype wire

// ===== design/dual_timebase_capture_timer.sv
// Dual timebase and input capture timer with its APB register slave
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - Hidden 8-bit counter one starts at zero, steps every 32 clocks.
// - Counter one counts modulo 250, overflowing on the F9h to 00h wrap.
// - Timebase one period is 8000 clocks, or 16000 with period select set.
// - Timebase one period end sets its flag; interrupt when its enable is set.
// - Reading the first control/status register clears timebase one flag.
// - Counter two is readable, starts at zero, steps every 32 clocks.
// - Counter two past FFh reloads from the reload register, not zero.
// - Reload writes allowed any time, used at the next counter two overflow.
// - Counter two overflow sets its flag; interrupt when its enable is set.
// - Reading the second control/status register clears timebase two flag.
// - Capture pin edge copies counter one, sets capture flag, may interrupt.
// - Reading the capture register clears the capture flag; writes ignored.
// - No new capture while the capture flag is set, except in the cycle a read clears it.
// - Halt stops both counters; other low power modes have no effect.
// - Three separate interrupts, each needs its enable and a clear mask.
// - Capture register is read-only and resets to zero.
// - First register: capture enable 7, flag 6, period 5, tb1 enable 4, flag 3.
module dual_timebase_capture_timer (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [lite_timer_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic capture_pin,
  input wire logic halt_mode,
  input wire logic irq_mask,
  output logic irq_timebase_one,
  output logic irq_timebase_two,
  output logic irq_capture
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  lite_timer_pkg::ctrl_t ctrl;
  logic [7:0] counter1;
  logic [7:0] counter2_value;
  logic [7:0] counter2_reload;
  logic [7:0] capture_value;
  logic timebase_one_flag;
  logic timebase_two_flag;
  logic capture_flag;
  logic half;
  logic tick;
  logic cap_edge;
  logic c1_wrap;
  logic tb1_event;
  logic tb2_event;
  logic cap_take;
  logic access;
  logic done;
  logic wr_done;
  logic rd_done;
  logic hit;
  logic [7:0] idx;
  logic [7:0] rd_byte;
  logic clr_tb1;
  logic clr_tb2;
  logic clr_cap;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  tick_divider u_div (
    .pclk(pclk),
    .presetn(presetn),
    .run(!halt_mode),
    .tick(tick)
  );

  edge_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin(capture_pin),
    .any_edge(cap_edge)
  );

  // ----------------------------------------------------------------
  // APB slave: one wait state, answer registered
  // ----------------------------------------------------------------
  assign idx = lite_timer_pkg::reg_index(paddr);
  assign hit = (idx >= lite_timer_pkg::IDX_CSR2) && (idx <= lite_timer_pkg::IDX_CAPTURE);
  assign access = psel && penable;
  assign done = access && pready;
  assign wr_done = done && pwrite && !pslverr;
  assign rd_done = done && !pwrite && !pslverr;

  // Read side effects happen at completion so a stalled read clears nothing
  assign clr_tb1 = rd_done && (idx == lite_timer_pkg::IDX_CSR1);
  assign clr_tb2 = rd_done && (idx == lite_timer_pkg::IDX_CSR2);
  assign clr_cap = rd_done && (idx == lite_timer_pkg::IDX_CAPTURE);

  always_comb begin
    rd_byte = lite_timer_pkg::ZERO8;
    unique case (idx)
      lite_timer_pkg::IDX_CSR2: begin
        rd_byte[lite_timer_pkg::B_TB2_IE] = ctrl.timebase_two_irq_enable;
        rd_byte[lite_timer_pkg::B_TB2_FLAG] = timebase_two_flag;
      end
      lite_timer_pkg::IDX_RELOAD: begin
        rd_byte = counter2_reload;
      end
      lite_timer_pkg::IDX_COUNT2: begin
        rd_byte = counter2_value;
      end
      lite_timer_pkg::IDX_CSR1: begin
        rd_byte[lite_timer_pkg::B_CAP_IE] = ctrl.capture_irq_enable;
        rd_byte[lite_timer_pkg::B_CAP_FLAG] = capture_flag;
        rd_byte[lite_timer_pkg::B_PERIOD] = ctrl.period_select;
        rd_byte[lite_timer_pkg::B_TB1_IE] = ctrl.timebase_one_irq_enable;
        rd_byte[lite_timer_pkg::B_TB1_FLAG] = timebase_one_flag;
      end
      lite_timer_pkg::IDX_CAPTURE: begin
        rd_byte = capture_value;
      end
      default: begin
        rd_byte = lite_timer_pkg::ZERO8;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      pready <= access && !pready;
      pslverr <= access && !pready && !hit;
      if (access && !pready) begin
        prdata <= {24'h00_0000, (pwrite || !hit) ? lite_timer_pkg::ZERO8 : rd_byte};
      end
    end
  end

  // ----------------------------------------------------------------
  // Control registers; flag bits ignore writes
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= lite_timer_pkg::CTRL_RESET;
    end else if (wr_done && idx == lite_timer_pkg::IDX_CSR1) begin
      ctrl.capture_irq_enable <= pwdata[lite_timer_pkg::B_CAP_IE];
      ctrl.period_select <= pwdata[lite_timer_pkg::B_PERIOD];
      ctrl.timebase_one_irq_enable <= pwdata[lite_timer_pkg::B_TB1_IE];
    end else if (wr_done && idx == lite_timer_pkg::IDX_CSR2) begin
      ctrl.timebase_two_irq_enable <= pwdata[lite_timer_pkg::B_TB2_IE];
    end
  end

  // Reload only stored here; counter two picks it up at its own overflow
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      counter2_reload <= lite_timer_pkg::ZERO8;
    end else if (wr_done && idx == lite_timer_pkg::IDX_RELOAD) begin
      counter2_reload <= pwdata[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Counter one and the timebase one event
  // ----------------------------------------------------------------
  assign c1_wrap = tick && (counter1 == lite_timer_pkg::C1_LAST);
  // Long period takes every second wrap rather than a wider counter
  assign tb1_event = c1_wrap && (!ctrl.period_select || half);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      counter1 <= lite_timer_pkg::ZERO8;
      half <= 1'b0;
    end else if (tick) begin
      counter1 <= c1_wrap ? lite_timer_pkg::ZERO8 : counter1 + 1'b1;
      if (c1_wrap) begin
        half <= !half;
      end
    end
  end

  // ----------------------------------------------------------------
  // Counter two with reload
  // ----------------------------------------------------------------
  assign tb2_event = tick && (counter2_value == lite_timer_pkg::C2_LAST);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      counter2_value <= lite_timer_pkg::ZERO8;
    end else if (tick) begin
      counter2_value <= tb2_event ? counter2_reload : counter2_value + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Event flags; a set in the clearing cycle wins
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timebase_one_flag <= 1'b0;
    end else begin
      timebase_one_flag <= tb1_event || (timebase_one_flag && !clr_tb1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timebase_two_flag <= 1'b0;
    end else begin
      timebase_two_flag <= tb2_event || (timebase_two_flag && !clr_tb2);
    end
  end

  // ----------------------------------------------------------------
  // Input capture
  // ----------------------------------------------------------------
  // An edge in the cycle the flag is cleared is still taken
  assign cap_take = cap_edge && (!capture_flag || clr_cap);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_value <= lite_timer_pkg::ZERO8;
      capture_flag <= 1'b0;
    end else begin
      if (cap_take) begin
        capture_value <= counter1;
      end
      capture_flag <= cap_take || (capture_flag && !clr_cap);
    end
  end

  // ----------------------------------------------------------------
  // Interrupt requests, one line per event
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_timebase_one <= 1'b0;
      irq_timebase_two <= 1'b0;
      irq_capture <= 1'b0;
    end else begin
      irq_timebase_one <= timebase_one_flag && ctrl.timebase_one_irq_enable && !irq_mask;
      irq_timebase_two <= timebase_two_flag && ctrl.timebase_two_irq_enable && !irq_mask;
      irq_capture <= capture_flag && ctrl.capture_irq_enable && !irq_mask;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic [14:0] gap;
  logic gap_valid;
  logic period_last;

  // Cycles since the last timebase one event, marked invalid on a period change or halt
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap <= '0;
      gap_valid <= 1'b0;
      period_last <= 1'b0;
    end else begin
      period_last <= ctrl.period_select;
      if (tb1_event) begin
        gap <= 15'd1;
        gap_valid <= 1'b1;
      end else begin
        gap <= (gap == '1) ? gap : gap + 1'b1;
        if (ctrl.period_select != period_last || halt_mode) begin
          gap_valid <= 1'b0;
        end
      end
    end
  end

  sequence s_quiet_ticks;
    (!tick) [*8];
  endsequence

  sequence s_reloaded;
    counter2_value == $past(counter2_reload);
  endsequence

  property p_tick_spacing;
    tick |=> s_quiet_ticks;
  endproperty
  a_tick_spacing: assert property (p_tick_spacing) else $error("tick spacing short");

  property p_c1_wrap;
    c1_wrap |=> counter1 == lite_timer_pkg::ZERO8 && $past(counter1) == lite_timer_pkg::C1_LAST;
  endproperty
  a_c1_wrap: assert property (p_c1_wrap) else $error("counter one wrap wrong");

  property p_tb1_period;
    (tb1_event && gap_valid) |-> gap == (ctrl.period_select ?
      15'(lite_timer_pkg::TB_LONG_OSC) : 15'(lite_timer_pkg::TB_SHORT_OSC));
  endproperty
  a_tb1_period: assert property (p_tb1_period) else $error("timebase one period wrong");

  property p_tb1_flag;
    tb1_event |=> timebase_one_flag ##1 (irq_timebase_one == (ctrl.timebase_one_irq_enable
      && !$past(irq_mask)) || !timebase_one_flag || !$stable(ctrl));
  endproperty
  a_tb1_flag: assert property (p_tb1_flag) else $error("timebase one flag or request wrong");

  property p_tb1_clear;
    (clr_tb1 && !tb1_event) |=> !timebase_one_flag;
  endproperty
  a_tb1_clear: assert property (p_tb1_clear) else $error("timebase one flag not cleared");

  property p_c2_reload;
    tb2_event |=> s_reloaded and timebase_two_flag;
  endproperty
  a_c2_reload: assert property (p_c2_reload) else $error("counter two reload wrong");

  property p_tb2_clear;
    (clr_tb2 && !tb2_event) |=> !timebase_two_flag;
  endproperty
  a_tb2_clear: assert property (p_tb2_clear) else $error("timebase two flag not cleared");

  property p_cap_take;
    cap_take |=> capture_flag && capture_value == $past(counter1);
  endproperty
  a_cap_take: assert property (p_cap_take) else $error("capture value wrong");

  property p_cap_hold;
    (capture_flag && !clr_cap) |=> $stable(capture_value) && capture_flag;
  endproperty
  a_cap_hold: assert property (p_cap_hold) else $error("capture overwritten");

  property p_halt;
    halt_mode |=> $stable(counter1) && $stable(counter2_value);
  endproperty
  a_halt: assert property (p_halt) else $error("counter moved in halt");

  property p_mask;
    irq_mask |=> !irq_timebase_one && !irq_timebase_two && !irq_capture;
  endproperty
  a_mask: assert property (p_mask) else $error("request while masked");

endmodule // dual_timebase_capture_timer
`default_nettype wire

// ===== verif/tb.sv
// Self-checking testbench of the dual timebase capture timer
`timescale 1ns/1ns
`default_nettype none
module tb;
  localparam int LIMIT = 100000;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic capture_pin;
  logic halt_mode;
  logic irq_mask;
  logic irq_timebase_one;
  logic irq_timebase_two;
  logic irq_capture;
  wire [2:0] irqv;
  logic [31:0] rd;
  logic err;
  logic [7:0] rl;
  logic [7:0] capv;
  int error_cnt;
  int n_tests;
  int seed;
  int cyc = 0;
  int wd = 0;
  int n;
  int t0;
  int t1;

  assign irqv = {irq_capture, irq_timebase_two, irq_timebase_one};

  dual_timebase_capture_timer uut (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .capture_pin(capture_pin),
    .halt_mode(halt_mode),
    .irq_mask(irq_mask),
    .irq_timebase_one(irq_timebase_one),
    .irq_timebase_two(irq_timebase_two),
    .irq_capture(irq_capture)
  );

  // ----------------------------------------------------------------
  // Clock, running cycle model and hang guard
  // ----------------------------------------------------------------
  always #5 pclk = ~pclk;

  // Counts only cycles in which the divider may advance, so halt is excluded
  always @(posedge pclk) begin
    if (presetn === 1'b1 && halt_mode === 1'b0) begin
      cyc <= cyc + 1;
    end
  end

  always @(posedge pclk) begin
    wd <= wd + 1;
    if (wd == LIMIT) begin
      error_cnt++;
      give_verdict();
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  function automatic logic [11:0] ad(input logic [7:0] idx);
    return {2'h0, idx, 2'h0};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Holds the request until pready is sampled high, then takes the answer
  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rd = prdata;
    err = pslverr;
    if (k >= 50) error_cnt++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Lets a previous read-clear reach the request line before polling
  task automatic wait_irq(input int k, output int t);
    int m;
    m = 0;
    repeat (3) @(posedge pclk);
    while (irqv[k] !== 1'b1 && m < 20000) begin
      @(posedge pclk);
      m++;
    end
    if (m >= 20000) error_cnt++;
    t = cyc;
  endtask

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    capture_pin = 1'b0;
    halt_mode = 1'b0;
    irq_mask = 1'b0;
    error_cnt = 0;
    n_tests = 0;
    seed = 32'h81b1;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;

    apb(1'b0, ad(lite_timer_pkg::IDX_COUNT2), 8'h00);
    check(rd, 32'h0);
    apb(1'b0, ad(lite_timer_pkg::IDX_CSR2), 8'h00);
    check(rd, 32'h0);
    apb(1'b0, ad(lite_timer_pkg::IDX_RELOAD), 8'h00);
    check(rd, 32'h0);
    apb(1'b0, ad(lite_timer_pkg::IDX_CSR1), 8'h00);
    check(rd, 32'h0);
    apb(1'b1, ad(lite_timer_pkg::IDX_CAPTURE), 8'h5a);
    apb(1'b0, ad(lite_timer_pkg::IDX_CAPTURE), 8'h00);
    check(rd, 32'h0);
    apb(1'b0, 12'h034, 8'h00);
    check({31'h0, err}, 32'h1);
    apb(1'b0, 12'h021, 8'h00);
    check({31'h0, err}, 32'h1);
    $display("test reset_map done");

    // Counter two reload, flag, mask and read-clear
    n = $random(seed);
    // Reload below FFh leaves time to clear the flag before the next overflow
    rl = 8'hc0 | (n[7:0] & 8'hfe);
    apb(1'b1, ad(lite_timer_pkg::IDX_RELOAD), rl);
    apb(1'b0, ad(lite_timer_pkg::IDX_RELOAD), 8'h00);
    check(rd, {24'h0, rl});
    apb(1'b1, ad(lite_timer_pkg::IDX_CSR2), 8'h03);
    wait_irq(1, t0);
    apb(1'b0, ad(lite_timer_pkg::IDX_COUNT2), 8'h00);
    check(rd, {24'h0, rl});
    irq_mask <= 1'b1;
    repeat (3) @(posedge pclk);
    check({31'h0, irq_timebase_two}, 32'h0);
    apb(1'b0, ad(lite_timer_pkg::IDX_CSR2), 8'h00);
    check(rd, 32'h3);
    apb(1'b0, ad(lite_timer_pkg::IDX_CSR2), 8'h00);
    check(rd, 32'h2);
    irq_mask <= 1'b0;
    n = $random(seed);
    apb(1'b1, ad(lite_timer_pkg::IDX_RELOAD), 8'h80 | n[7:0]);
    wait_irq(1, t1);
    check(t1 - t0, (256 - int'(rl)) * 32);
    apb(1'b0, ad(lite_timer_pkg::IDX_COUNT2), 8'h00);
    check(rd, {24'h0, 8'h80 | n[7:0]});
    $display("test counter_two done");

    // Halt freezes counter two
    halt_mode <= 1'b1;
    apb(1'b0, ad(lite_timer_pkg::IDX_COUNT2), 8'h00);
    capv = rd[7:0];
    repeat (70) @(posedge pclk);
    apb(1'b0, ad(lite_timer_pkg::IDX_COUNT2), 8'h00);
    check(rd, {24'h0, capv});
    halt_mode <= 1'b0;
    $display("test halt done");

    // Timebase one period, both settings
    for (int p = 0; p < 2; p++) begin
      apb(1'b1, ad(lite_timer_pkg::IDX_CSR1), (p == 1) ? 8'h30 : 8'h10);
      // Drop a flag left from earlier events so t0 marks a fresh overflow
      apb(1'b0, ad(lite_timer_pkg::IDX_CSR1), 8'h00);
      apb(1'b0, ad(lite_timer_pkg::IDX_CSR1), 8'h00);
      wait_irq(0, t0);
      apb(1'b0, ad(lite_timer_pkg::IDX_CSR1), 8'h00);
      check(rd & 32'h0000_00f8, (p == 1) ? 32'h0000_0038 : 32'h0000_0018);
      apb(1'b0, ad(lite_timer_pkg::IDX_CSR1), 8'h00);
      check(rd & 32'h0000_0008, 32'h0);
      wait_irq(0, t1);
      check(t1 - t0, (p == 1) ? 16000 : 8000);
    end
    $display("test timebase_one done");

    // Capture, with a second edge while the flag is still set
    apb(1'b1, ad(lite_timer_pkg::IDX_CSR1), 8'h80);
    apb(1'b0, ad(lite_timer_pkg::IDX_CAPTURE), 8'h00);
    n = $random(seed);
    repeat (int'(n[3:0]) * 32 + 5) @(posedge pclk);
    // Toggle mid-tick so synchroniser latency cannot shift the value
    while (cyc % 32 != 16) @(posedge pclk);
    capture_pin <= ~capture_pin;
    capv = 8'((cyc / 32) % 250);
    repeat (8) @(posedge pclk);
    check({31'h0, irq_capture}, 32'h1);
    repeat (64) @(posedge pclk);
    capture_pin <= ~capture_pin;
    repeat (8) @(posedge pclk);
    apb(1'b0, ad(lite_timer_pkg::IDX_CSR1), 8'h00);
    check(rd & 32'h0000_0040, 32'h0000_0040);
    apb(1'b0, ad(lite_timer_pkg::IDX_CAPTURE), 8'h00);
    check(rd, {24'h0, capv});
    apb(1'b0, ad(lite_timer_pkg::IDX_CSR1), 8'h00);
    check(rd & 32'h0000_0040, 32'h0);
    $display("test capture done");
    give_verdict();
  end
endmodule // tb
`default_nettype wire
